// *** rtl/irp_pkg.sv ***
// constants, types and helpers shared by the register port design
package irp_pkg;

  // bus identity: 7-bit target address, direction bit follows
  localparam logic [6:0] DEV_ADDR      = 7'h35;
  localparam logic [7:0] ADDR_BYTE_RD  = 8'h6b;
  localparam logic [7:0] ADDR_BYTE_WR  = 8'h6a;

  // bit counting within one byte frame
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK_SLOT  = 4'h8;

  // register space layout
  localparam logic [7:0] REG_REVISION  = 8'h00;
  localparam logic [7:0] REG_INT_FIRST = 8'h01;
  localparam logic [7:0] REG_INT_LAST  = 8'h05;
  localparam logic [7:0] REG_STAT_FIRST = 8'h07;
  localparam logic [7:0] REG_STAT_LAST = 8'h0b;
  localparam logic [7:0] REG_MASK_FIRST = 8'h0c;
  localparam logic [7:0] REG_COMMON_CONTROL_ONE = 8'h15;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;

  // fields of common_control_one
  localparam int unsigned CTL_IRQ_OUTPUT_ENABLE = 7;
  localparam int unsigned CTL_DEEP_SLEEP_SELECT = 0;

  // fields of the first interrupt byte fed by the block itself
  localparam int unsigned INT_FAULT_BIT = 7;
  localparam int unsigned INT_WAKE_BIT  = 2;

  // implemented address windows
  localparam logic [7:0] WIN0_LO = 8'h00;
  localparam logic [7:0] WIN0_HI = 8'h11;
  localparam logic [7:0] WIN1_LO = 8'h15;
  localparam logic [7:0] WIN1_HI = 8'h1a;
  localparam logic [7:0] WIN2_LO = 8'h20;
  localparam logic [7:0] WIN2_HI = 8'h26;
  localparam logic [7:0] WIN3_LO = 8'h28;
  localparam logic [7:0] WIN4_LO = 8'h2a;
  localparam logic [7:0] WIN4_HI = 8'h3f;
  localparam logic [7:0] WIN5_LO = 8'h50;
  localparam logic [7:0] WIN5_HI = 8'h63;

  // timing
  localparam int unsigned CORE_PERIOD_NS = 40;
  localparam int unsigned SCL_MAX_KHZ    = 1000;
  localparam int unsigned SCL_MIN_HALF_NS = 1000000 / (SCL_MAX_KHZ * 2);
  localparam int unsigned SCL_HALF_CYC   = SCL_MIN_HALF_NS / CORE_PERIOD_NS;
  localparam int unsigned WAKE_LOW_NS    = 50;
  localparam int unsigned WAKE_LOW_CYC   = (WAKE_LOW_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam logic [3:0]  WAKE_CNT_MAX   = 4'(WAKE_LOW_CYC);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ADDR  = 3'h1,
    ST_REG   = 3'h2,
    ST_WDATA = 3'h3,
    ST_RDATA = 3'h4,
    ST_SKIP  = 3'h5
  } irp_state_t;

  // register address is part of the implemented map
  function automatic logic reg_valid(input logic [7:0] a);
    reg_valid = (a <= WIN0_HI) ||
                (a >= WIN1_LO && a <= WIN1_HI) ||
                (a >= WIN2_LO && a <= WIN2_HI) ||
                (a == WIN3_LO) ||
                (a >= WIN4_LO && a <= WIN4_HI) ||
                (a >= WIN5_LO && a <= WIN5_HI);
  endfunction

  // pointer step, register zero holds its place
  function automatic logic [7:0] ptr_next(input logic [7:0] p);
    ptr_next = (p == WIN0_LO) ? p : 8'(p + 8'h01);
  endfunction

endpackage

// *** rtl/irp_link_if.sv ***
// carrier between the serial-clock capture stage and the core engine
`timescale 1ns/1ns
`default_nettype none
interface irp_link_if;
  logic [7:0] rx_shift;

  modport link (output rx_shift);
  modport core (input  rx_shift);
endinterface
`default_nettype wire

// *** rtl/irp_link_rx.sv ***
// data capture on the rising serial clock edge
`timescale 1ns/1ns
`default_nettype none
module irp_link_rx (
  input  wire logic scl_clk,
  input  wire logic sda_in,
  irp_link_if.link  lnk
);

  logic [7:0] shift_ff;

  // no reset: scl may stand still, core only reads after a counted rise
  always_ff @(posedge scl_clk) begin
    shift_ff <= {shift_ff[6:0], sda_in};
  end

  assign lnk.rx_shift = shift_ff;

endmodule
`default_nettype wire

// *** rtl/irp_i2c_port.sv ***
// two-wire register port with event pin and wake from deep sleep
`timescale 1ns/1ns
`default_nettype none
// How it works
// - respond only to target address 0x35 followed by direction bit
// - serial clock may run up to 1000 kHz, not faster
// - data bits taken on rising clock edge, stable while clock high
// - data change while clock high is start, repeated start or stop
// - both lines released and high when idle
// - ack matching address, then ack register address only if valid
// - single write stores one data byte with ack, then stop
// - burst write advances pointer per byte, except at register zero
// - burst write may carry further bytes, each acked
// - deep sleep keeps only serial port and attach monitoring alive
// - in deep sleep, low on either line over 50 ns wakes
// - any status bit change raises a pending interrupt
// - disabled event output masks pin but keeps pending bits
// - with events disabled pin flags bad charger or factory cable
// - faults show as flag or event by enable, flag clears when cooled
// - burst read acks each byte except last which gets nack
// - ack holds data low through ninth clock high, nack leaves high
module irp_i2c_port #(
  parameter int unsigned STAT_BYTES = 5,
  parameter logic [7:0]  REV_CODE   = 8'h5a // arbitrary value
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    scl_clk,
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe,
  input  wire logic [STAT_BYTES*8-1:0] status_in,
  input  wire logic                    ovp_fault,
  input  wire logic                    thermal_fault,
  input  wire logic                    bad_charger,
  input  wire logic                    uart_cable,
  output logic                         int_n_out,
  output logic                         int_n_oe,
  output logic                         func_enable,
  output logic                         irq_output_enable
);

  localparam int unsigned SW = STAT_BYTES * 8;

  // refuse settings the map and the sampling rate cannot serve
  if (STAT_BYTES < 1 || STAT_BYTES > 5) begin : g_bad_stat
    $error("status byte count must be 1 to 5");
  end
  if (irp_pkg::SCL_HALF_CYC < 6) begin : g_bad_rate
    $error("core clock too slow to oversample the serial clock");
  end

  // capture stage in the serial clock domain
  irp_link_if lnk ();

  irp_link_rx u_rx (
    .scl_clk (scl_clk),
    .sda_in  (sda_in),
    .lnk     (lnk)
  );

  // pin synchronisers and edge history
  logic scl_s1_ff;
  logic scl_s2_ff;
  logic scl_q_ff;
  logic sda_s1_ff;
  logic sda_s2_ff;
  logic sda_q_ff;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_q_ff  <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_q_ff  <= 1'b1;
    end else begin
      scl_s1_ff <= scl_in;
      scl_s2_ff <= scl_s1_ff;
      scl_q_ff  <= scl_s2_ff;
      sda_s1_ff <= sda_in;
      sda_s2_ff <= sda_s1_ff;
      sda_q_ff  <= sda_s2_ff;
    end
  end

  // bus conditions: data moving while clock stays high is never data
  logic bus_start;
  logic bus_stop;
  logic scl_rise;
  logic scl_fall;

  assign bus_start = scl_q_ff & scl_s2_ff & sda_q_ff & ~sda_s2_ff;
  assign bus_stop  = scl_q_ff & scl_s2_ff & ~sda_q_ff & sda_s2_ff;
  assign scl_rise  = ~scl_q_ff & scl_s2_ff;
  assign scl_fall  = scl_q_ff & ~scl_s2_ff;

  // byte engine state
  irp_pkg::irp_state_t state_ff;
  logic [3:0]          bit_cnt_ff;
  logic                ack_ff;
  logic [7:0]          ptr_ff;
  logic [7:0]          rx_byte;
  logic                byte_done;
  logic                wr_evt;
  logic                rd_evt;

  // the capture stage moved its last bit before the synced rise is seen
  assign rx_byte   = lnk.rx_shift;
  assign byte_done = scl_rise & ~bus_start & ~bus_stop &
                     (state_ff != irp_pkg::ST_IDLE) &
                     (bit_cnt_ff == irp_pkg::BIT_LAST_DATA);
  assign wr_evt    = byte_done & (state_ff == irp_pkg::ST_WDATA);
  assign rd_evt    = scl_fall & (state_ff == irp_pkg::ST_RDATA) &
                     (bit_cnt_ff == 4'h0);

  // frame sequencing, one step per synced clock rise
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff   <= irp_pkg::ST_IDLE;
      bit_cnt_ff <= 4'h0;
      ack_ff     <= 1'b0;
      ptr_ff     <= irp_pkg::REG_RESET_VAL;
    end else if (bus_start) begin
      state_ff   <= irp_pkg::ST_ADDR;
      bit_cnt_ff <= 4'h0;
      ack_ff     <= 1'b0;
    end else if (bus_stop) begin
      state_ff   <= irp_pkg::ST_IDLE;
      bit_cnt_ff <= 4'h0;
      ack_ff     <= 1'b0;
    end else if (scl_rise && state_ff != irp_pkg::ST_IDLE) begin
      if (bit_cnt_ff == irp_pkg::BIT_ACK_SLOT) begin
        bit_cnt_ff <= 4'h0;
        ack_ff     <= 1'b0;
        // host answer in the ninth bit of a read; a set ack_ff means the
        // slot held our own address ack, which must not step the pointer
        if (state_ff == irp_pkg::ST_RDATA && !ack_ff) begin
          if (sda_s2_ff) begin
            state_ff <= irp_pkg::ST_SKIP;
          end else begin
            ptr_ff <= irp_pkg::ptr_next(ptr_ff);
          end
        end
      end else begin
        bit_cnt_ff <= 4'(bit_cnt_ff + 4'h1);
        if (bit_cnt_ff == irp_pkg::BIT_LAST_DATA) begin
          unique case (state_ff)
            irp_pkg::ST_ADDR: begin
              if (rx_byte[7:1] == irp_pkg::DEV_ADDR) begin
                ack_ff   <= 1'b1;
                // low direction bit writes, high reads
                state_ff <= rx_byte[0] ? irp_pkg::ST_RDATA : irp_pkg::ST_REG;
              end else begin
                state_ff <= irp_pkg::ST_SKIP;
              end
            end
            irp_pkg::ST_REG: begin
              if (irp_pkg::reg_valid(rx_byte)) begin
                ptr_ff   <= rx_byte;
                ack_ff   <= 1'b1;
                state_ff <= irp_pkg::ST_WDATA;
              end else begin
                state_ff <= irp_pkg::ST_SKIP;
              end
            end
            irp_pkg::ST_WDATA: begin
              ack_ff <= 1'b1;
              ptr_ff <= irp_pkg::ptr_next(ptr_ff);
            end
            irp_pkg::ST_IDLE, irp_pkg::ST_RDATA, irp_pkg::ST_SKIP: begin
              ack_ff <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // register storage
  logic [7:0] regs_ff [0:255];
  logic [SW-1:0] pend_ff;
  logic [SW-1:0] stat_q_ff;
  logic       wake_evt_ff;
  logic       writable;
  logic [7:0] rd_val;
  logic       in_int;
  logic       in_stat;
  logic [2:0] int_idx;
  logic [2:0] stat_idx;

  // address classes for reads and writes
  always_comb begin
    in_int   = (ptr_ff >= irp_pkg::REG_INT_FIRST) &&
               (ptr_ff <  irp_pkg::REG_INT_FIRST + 8'(STAT_BYTES));
    in_stat  = (ptr_ff >= irp_pkg::REG_STAT_FIRST) &&
               (ptr_ff <  irp_pkg::REG_STAT_FIRST + 8'(STAT_BYTES));
    int_idx  = 3'(ptr_ff - irp_pkg::REG_INT_FIRST);
    stat_idx = 3'(ptr_ff - irp_pkg::REG_STAT_FIRST);
    writable = (ptr_ff != irp_pkg::REG_REVISION) && !in_int && !in_stat;
    if (ptr_ff == irp_pkg::REG_REVISION) begin
      rd_val = REV_CODE;
    end else if (in_int) begin
      rd_val = pend_ff[int_idx*8 +: 8];
    end else if (in_stat) begin
      rd_val = status_in[stat_idx*8 +: 8];
    end else begin
      rd_val = regs_ff[ptr_ff];
    end
  end

  // plain registers; hardware wake clears the sleep select bit
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < 256; i++) begin
        regs_ff[i] <= irp_pkg::REG_RESET_VAL;
      end
    end else begin
      if (wr_evt && writable) begin
        regs_ff[ptr_ff] <= rx_byte;
      end
      if (wake_evt_ff) begin
        regs_ff[irp_pkg::REG_COMMON_CONTROL_ONE][irp_pkg::CTL_DEEP_SLEEP_SELECT] <= 1'b0;
      end
    end
  end

  // transmit path: change sda only after a synced fall, hold through high
  logic [7:0] tx_ff;
  logic       oe_ff;

  always_ff @(posedge core_clk) begin
    if (rst || bus_start || bus_stop) begin
      oe_ff <= 1'b0;
      tx_ff <= 8'h00;
    end else if (scl_fall) begin
      if (bit_cnt_ff == irp_pkg::BIT_ACK_SLOT) begin
        oe_ff <= ack_ff;
      end else if (rd_evt) begin
        tx_ff <= {rd_val[6:0], 1'b0};
        oe_ff <= ~rd_val[7];
      end else if (state_ff == irp_pkg::ST_RDATA) begin
        tx_ff <= {tx_ff[6:0], 1'b0};
        oe_ff <= ~tx_ff[7];
      end else begin
        oe_ff <= 1'b0;
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = oe_ff;

  // pending events: set beats a read clear in the same cycle
  logic [SW-1:0] pend_set;
  logic [SW-1:0] pend_clr;
  logic          fault_q_ff;
  logic          fault_now;

  assign fault_now = ovp_fault | thermal_fault;

  always_comb begin
    pend_set = status_in ^ stat_q_ff;
    pend_set[irp_pkg::INT_FAULT_BIT] = pend_set[irp_pkg::INT_FAULT_BIT] |
                                       (fault_now ^ fault_q_ff);
    pend_set[irp_pkg::INT_WAKE_BIT]  = pend_set[irp_pkg::INT_WAKE_BIT] | wake_evt_ff;
    pend_clr = '0;
    if (rd_evt && in_int) begin
      pend_clr[int_idx*8 +: 8] = 8'hff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pend_ff    <= '0;
      stat_q_ff  <= '0;
      fault_q_ff <= 1'b0;
    end else begin
      // kept even while the pin is disabled
      pend_ff    <= pend_set | (pend_ff & ~pend_clr);
      stat_q_ff  <= status_in;
      fault_q_ff <= fault_now;
    end
  end

  // wake detector: consecutive low samples of either line
  logic [3:0] low_cnt_ff;
  logic       sleep_sel;

  assign sleep_sel = regs_ff[irp_pkg::REG_COMMON_CONTROL_ONE][irp_pkg::CTL_DEEP_SLEEP_SELECT];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      low_cnt_ff  <= 4'h0;
      wake_evt_ff <= 1'b0;
    end else begin
      wake_evt_ff <= 1'b0;
      if (!sleep_sel || (scl_s2_ff && sda_s2_ff)) begin
        low_cnt_ff <= 4'h0;
      end else if (low_cnt_ff == irp_pkg::WAKE_CNT_MAX - 4'h1) begin
        low_cnt_ff  <= 4'h0;
        wake_evt_ff <= 1'b1;
      end else begin
        low_cnt_ff <= 4'(low_cnt_ff + 4'h1);
      end
    end
  end

  // event pin and function gating
  logic [SW-1:0] mask_vec;
  logic          irq_en;
  logic          int_oe_ff;
  logic          func_en_ff;

  always_comb begin
    for (int i = 0; i < STAT_BYTES; i++) begin
      mask_vec[i*8 +: 8] = regs_ff[irp_pkg::REG_MASK_FIRST + 8'(i)];
    end
  end

  assign irq_en = regs_ff[irp_pkg::REG_COMMON_CONTROL_ONE][irp_pkg::CTL_IRQ_OUTPUT_ENABLE];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      int_oe_ff  <= 1'b0;
      func_en_ff <= 1'b1;
    end else begin
      if (irq_en) begin
        int_oe_ff <= |(pend_ff & ~mask_vec);
      end else begin
        // flag mode: live level, so a cooled die releases it
        int_oe_ff <= bad_charger | uart_cable | fault_now;
      end
      // the port and attach monitor stay outside this gate
      func_en_ff <= ~sleep_sel;
    end
  end

  assign int_n_out         = 1'b0;
  assign int_n_oe          = int_oe_ff;
  assign func_enable       = func_en_ff;
  assign irq_output_enable = irq_en;

endmodule
`default_nettype wire

// *** dv/irp_i2c_port_asserts.sv ***
// port-level checker for the two-wire register port
`timescale 1ns/1ns
`default_nettype none
module irp_i2c_port_asserts #(
  parameter int unsigned STAT_BYTES = 5
) (
  input wire logic                    core_clk,
  input wire logic                    rst,
  input wire logic                    scl_clk,
  input wire logic                    scl_in,
  input wire logic                    sda_in,
  input wire logic                    sda_out,
  input wire logic                    sda_oe,
  input wire logic [STAT_BYTES*8-1:0] status_in,
  input wire logic                    ovp_fault,
  input wire logic                    thermal_fault,
  input wire logic                    bad_charger,
  input wire logic                    uart_cable,
  input wire logic                    int_n_out,
  input wire logic                    int_n_oe,
  input wire logic                    func_enable,
  input wire logic                    irq_output_enable
);
  logic [3:0] low_cnt_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // cycles since the clock line fell, saturating
  always_ff @(posedge core_clk) begin
    if (rst || scl_in) low_cnt_ff <= 4'h0;
    else if (low_cnt_ff != 4'hf) low_cnt_ff <= low_cnt_ff + 4'h1;
  end
  chk_reset_quiet: assert property ($fell(rst) |-> !sda_oe && !int_n_oe && func_enable)
    else $error("outputs not quiet after reset");
  chk_sda_open_drain: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  chk_pin_open_drain: assert property (int_n_out == 1'b0)
    else $error("event pin driven high");
  chk_flag_follow: assert property (
    !irq_output_enable && !$past(irq_output_enable) && !$past(rst)
    |-> int_n_oe == $past(bad_charger || uart_cable || ovp_fault || thermal_fault))
    else $error("flag pin does not follow conditions");
  // data pin may only move early in the clock low phase
  chk_drive_rise_time: assert property ($rose(sda_oe) |-> !scl_in && low_cnt_ff inside {[2:5]})
    else $error("data pulled low outside low phase");
  chk_drive_fall_time: assert property ($fell(sda_oe) |-> !scl_in && low_cnt_ff inside {[2:5]})
    else $error("data released outside low phase");
  chk_ack_hold: assert property ($rose(scl_in) && sda_oe |=> sda_oe [*4])
    else $error("ack dropped during clock high");
  chk_wake_time: assert property (
    (!func_enable && !scl_in) ##1 (!scl_in) [*6] |-> ##[0:2] func_enable)
    else $error("no wake on low clock line");
  cov_ack: cover property ($rose(sda_oe));
  cov_sleep: cover property ($fell(func_enable));
  cov_irq: cover property (irq_output_enable && $rose(int_n_oe));
endmodule
bind irp_i2c_port irp_i2c_port_asserts #(.STAT_BYTES(STAT_BYTES)) u_chk (
  .core_clk(core_clk), .rst(rst), .scl_clk(scl_clk), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .status_in(status_in), .ovp_fault(ovp_fault),
  .thermal_fault(thermal_fault), .bad_charger(bad_charger), .uart_cable(uart_cable),
  .int_n_out(int_n_out), .int_n_oe(int_n_oe), .func_enable(func_enable),
  .irq_output_enable(irq_output_enable));
`default_nettype wire

// *** dv/irp_host_model.sv ***
// two-wire host controller model with its own bit timer
`timescale 1ns/1ns
`default_nettype none
module irp_host_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  logic tck;
  // 48 ns bit timer, unrelated in phase to the core clock
  initial begin
    tck = 1'b0;
    #7;
    forever #24 tck = ~tck;
  end
  // both lines released while idle
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge tck);
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    sda_low = 1'b0;
    w(5);
    scl = 1'b1;
    w(11);
    sda_low = 1'b1;
    w(11);
    scl = 1'b0;
    w(6);
  endtask
  // stop: data rises while clock high
  task automatic stop();
    sda_low = 1'b1;
    w(5);
    scl = 1'b1;
    w(11);
    sda_low = 1'b0;
    w(11);
  endtask
  // one bit, 528 ns each phase keeps the rate under 1 MHz
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    w(5);
    scl = 1'b1;
    w(5);
    s = sda;
    w(6);
    scl = 1'b0;
    w(6);
  endtask
  // byte out msb first, ack sampled in ninth slot
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // byte in, ack for all but the last byte
  task automatic recv(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~ack, s);
  endtask
endmodule
`default_nettype wire

// *** dv/i2c_register_port_with_wake_tb_top.sv ***
// self-checking bench for the two-wire register port
`timescale 1ns/1ns
`default_nettype none
module i2c_register_port_with_wake_tb_top;
  localparam logic [7:0] REV = 8'h5a; // arbitrary value
  logic        core_clk;
  logic        rst;
  logic [39:0] status_in;
  logic [3:0]  flags;
  logic        h_scl;
  logic        h_low;
  logic        sda_out;
  logic        sda_oe;
  logic        int_n_out;
  logic        int_n_oe;
  logic        func_enable;
  logic        irq_en;
  logic        saw_sleep;
  int          fails;
  int          n_compared;
  wire logic   sda;
  // pulled-up data wire, low while any party pulls it
  assign sda = ~(h_low | (sda_oe & ~sda_out));
  irp_i2c_port #(.STAT_BYTES(5), .REV_CODE(REV)) dut (
    .core_clk(core_clk), .rst(rst), .scl_clk(h_scl), .scl_in(h_scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .status_in(status_in), .ovp_fault(flags[1]),
    .thermal_fault(flags[0]), .bad_charger(flags[3]), .uart_cable(flags[2]),
    .int_n_out(int_n_out), .int_n_oe(int_n_oe), .func_enable(func_enable),
    .irq_output_enable(irq_en));
  irp_host_model h (.scl(h_scl), .sda_low(h_low), .sda(sda));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // sleep is short-lived, so remember that it happened
  always @(negedge func_enable) saw_sleep = 1'b1;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: got %h want %h", $time, m, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic xfer_wr(input logic [7:0] r, input logic [7:0] q[$], input logic ok);
    logic a;
    h.start();
    h.send(8'h6a, a);
    chk(8'(a), 8'h01, "addr ack");
    h.send(r, a);
    chk(8'(a), 8'(ok), "reg ack");
    foreach (q[i]) begin
      h.send(q[i], a);
      if (ok) chk(8'(a), 8'h01, "data ack");
    end
    h.stop();
  endtask
  task automatic xfer_rd(input logic [7:0] r, input logic [7:0] exp[$]);
    logic a;
    logic [7:0] d;
    h.start();
    h.send(8'h6a, a);
    h.send(r, a);
    h.start();
    h.send(8'h6b, a);
    chk(8'(a), 8'h01, "read addr ack");
    foreach (exp[i]) begin
      h.recv(i != exp.size() - 1, d);
      chk(d, exp[i], "read data");
    end
    h.stop();
  endtask
  task automatic t_addr();
    logic a;
    for (int i = 0; i < 2; i++) begin
      h.start();
      h.send(i == 0 ? 8'h6c : 8'h68, a);
      chk(8'(a), 8'h00, "foreign addr");
      h.send(8'h6a, a);
      chk(8'(a), 8'h00, "byte after foreign addr");
      h.stop();
    end
    $display("t_addr done");
  endtask
  task automatic t_burst();
    xfer_wr(8'h20, '{8'h11, 8'h22, 8'h33}, 1'b1);
    xfer_rd(8'h20, '{8'h11, 8'h22, 8'h33});
    xfer_wr(8'h28, '{8'h5c}, 1'b1);
    xfer_rd(8'h28, '{8'h5c});
    xfer_wr(8'h11, '{8'h9a}, 1'b1);
    xfer_rd(8'h11, '{8'h9a});
    $display("t_burst done");
  endtask
  task automatic t_invalid();
    logic [7:0] q[$];
    q = '{8'h12, 8'h27, 8'h29, 8'h40, 8'h64};
    foreach (q[i]) xfer_wr(q[i], '{8'h77}, 1'b0);
    xfer_rd(8'h11, '{8'h9a});
    $display("t_invalid done");
  endtask
  task automatic t_zero();
    xfer_wr(8'h00, '{8'h12, 8'h34}, 1'b1);
    xfer_rd(8'h00, '{REV, REV});
    $display("t_zero done");
  endtask
  task automatic t_irq();
    xfer_wr(8'h15, '{8'h80}, 1'b1);
    chk(8'(irq_en), 8'h01, "irq enable bit");
    @(negedge core_clk) status_in[7:0] = 8'h05;
    cyc(4);
    chk(8'(int_n_oe), 8'h01, "irq on change");
    xfer_rd(8'h01, '{8'h05});
    cyc(4);
    chk(8'(int_n_oe), 8'h00, "irq after read");
    xfer_wr(8'h0c, '{8'hff}, 1'b1);
    @(negedge core_clk) status_in[7:0] = 8'h00;
    cyc(4);
    chk(8'(int_n_oe), 8'h00, "masked irq");
    xfer_rd(8'h01, '{8'h05});
    xfer_wr(8'h15, '{8'h00}, 1'b1);
    @(negedge core_clk) status_in[15:8] = 8'h30;
    cyc(4);
    chk(8'(int_n_oe), 8'h00, "irq held off");
    xfer_wr(8'h15, '{8'h80}, 1'b1);
    cyc(4);
    chk(8'(int_n_oe), 8'h01, "pending kept");
    xfer_rd(8'h02, '{8'h30});
    $display("t_irq done");
  endtask
  task automatic t_flags();
    xfer_wr(8'h15, '{8'h00}, 1'b1);
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk) flags = 4'(1 << i);
      cyc(4);
      chk(8'(int_n_oe), 8'h01, "flag set");
      flags = 4'h0;
      cyc(4);
      chk(8'(int_n_oe), 8'h00, "flag clear");
    end
    $display("t_flags done");
  endtask
  task automatic t_sleep();
    saw_sleep = 1'b0;
    xfer_wr(8'h15, '{8'h01}, 1'b1);
    cyc(4);
    chk(8'(saw_sleep), 8'h01, "sleep entered");
    chk(8'(func_enable), 8'h01, "woken by bus");
    xfer_rd(8'h15, '{8'h00});
    xfer_rd(8'h01, '{8'h84});
    $display("t_sleep done");
  endtask
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog against a hung transfer
  initial begin
    #3000000;
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
  // reset, then the scenarios in order
  initial begin
    rst = 1'b1;
    status_in = 40'h0;
    flags = 4'h0;
    saw_sleep = 1'b0;
    fails = 0;
    n_compared = 0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    cyc(4);
    chk({5'h00, sda_oe, int_n_oe, irq_en}, 8'h00, "reset outputs");
    chk(8'(func_enable), 8'h01, "reset func");
    $display("t_reset done");
    t_addr();
    t_burst();
    t_invalid();
    t_zero();
    t_irq();
    t_flags();
    t_sleep();
    results();
  end
endmodule
`default_nettype wire
